//--- rtl/fsc_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Shared constants and types of the fan spin-up controller.
package fsc_pkg;

    // Clock period of pclk in nanoseconds.
    localparam int unsigned CLK_PERIOD_NS    = 25;
    // Base spin-up interval (0.05 s) in nanoseconds; longer codes double it.
    localparam int unsigned SPIN_UNIT_NS     = 50_000_000;
    // Clock cycles in one base interval.
    localparam int unsigned SPIN_UNIT_CYCLES = SPIN_UNIT_NS / CLK_PERIOD_NS;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0]  IDX_TACH_CFG  = 8'h03;
    localparam logic [7:0]  IDX_SPIN_CFG  = 8'h4b;
    localparam logic [7:0]  IDX_LEVEL     = 8'h4c;
    localparam logic [11:0] ADDR_TACH_CFG = {2'b00, IDX_TACH_CFG, 2'b00};
    localparam logic [11:0] ADDR_SPIN_CFG = {2'b00, IDX_SPIN_CFG, 2'b00};
    localparam logic [11:0] ADDR_LEVEL    = {2'b00, IDX_LEVEL, 2'b00};

    // Values after reset.
    localparam logic [7:0]  SPIN_CFG_RST  = 8'h3f;
    localparam logic [7:0]  TACH_CFG_RST  = 8'h00;

    // Field positions.
    localparam int unsigned FAST_BIT      = 5;
    localparam int unsigned DUTY_LSB      = 3;
    localparam int unsigned TIME_LSB      = 0;
    localparam int unsigned TACH_SEL_BIT  = 2;

    // PWM compare values on a 64-step period; 64 means always on.
    localparam logic [6:0]  DUTY_OFF      = 7'h00;
    localparam logic [6:0]  DUTY_HALF     = 7'h20;
    localparam logic [6:0]  DUTY_3Q       = 7'h30;
    localparam logic [6:0]  DUTY_FULL     = 7'h40;

    // Spin-up sequencer states.
    typedef enum logic [0:0] {
        FSC_IDLE = 1'b0,
        FSC_SPIN = 1'b1
    } fsc_state_t;

endpackage : fsc_pkg

//--- rtl/fsc_top.sv
// The APB register port was left to the implementer.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Bits 7:6 of the spin-up configuration register are unused and always read zero.
// - With fast start cleared, spin-up uses the programmed duty and interval fields.
// - With fast start set, full duty runs until the interval ends or, with the shared pin set as tach input, tach speed is reached.
// - With fast start set, the duty field is ignored and spin-up duty is always full.
// - An interval code of zero bypasses spin-up even with fast start set.
// - A duty code of zero bypasses spin-up unless fast start is set.
// - Duty codes 01, 10 and 11 give half, about three quarter and full duty.
// - Interval codes 1 to 7 give 0.05 s doubling up to 3.2 s.
// - The current level register reads zero while spin-up is running.
module fsc_top #(
    parameter int unsigned UNIT_CYCLES = fsc_pkg::SPIN_UNIT_CYCLES
) (
    input  wire logic        pclk,             // APB clock, 40 MHz.
    input  wire logic        presetn,          // Asynchronous reset, active low.
    input  wire logic        psel,             // APB select.
    input  wire logic        penable,          // APB access phase.
    input  wire logic        pwrite,           // APB write direction.
    input  wire logic [11:0] paddr,            // APB byte address.
    input  wire logic [31:0] pwdata,           // APB write data.
    output logic      [31:0] prdata,           // APB read data.
    output logic             pready,           // APB ready.
    output logic             pslverr,          // APB error for unmapped address.
    input  wire logic [5:0]  commanded_level,  // Level from normal fan control.
    input  wire logic        tach_at_setpoint, // Tach speed reached setpoint.
    output logic             pwm_out,          // Open-drain PWM output value.
    output logic             pwm_oe,           // PWM pin pulled low while high.
    output logic             spin_active       // Spin-up phase running.
);

    localparam int unsigned PW = $clog2(UNIT_CYCLES + 1);

    fsc_pkg::fsc_state_t state_reg;
    fsc_pkg::fsc_state_t state_next;
    logic [7:0]    spin_cfg_reg;
    logic [7:0]    tach_cfg_reg;
    logic [5:0]    level_prev_reg;
    logic [PW-1:0] pre_cnt_reg;
    logic [6:0]    ticks_left_reg;
    logic [5:0]    pwm_cnt_reg;
    logic          setup;
    logic          access;
    logic          fast;
    logic          tach_sel;
    logic [1:0]    duty_sel;
    logic [2:0]    time_sel;
    logic          start;
    logic          bypass;
    logic          unit_tick;
    logic          tach_done;
    logic [6:0]    spin_cmp;
    logic [6:0]    cmp;
    logic [6:0]    interval_ticks;
    logic [5:0]    level_view;

    ////////////////////////////////////////////////////////////////////////////
    // Field decode of the configuration registers.
    assign fast     = spin_cfg_reg[fsc_pkg::FAST_BIT];
    assign duty_sel = spin_cfg_reg[fsc_pkg::DUTY_LSB +: 2];
    assign time_sel = spin_cfg_reg[fsc_pkg::TIME_LSB +: 3];
    assign tach_sel = tach_cfg_reg[fsc_pkg::TACH_SEL_BIT];

    // APB phases.
    assign setup  = psel & ~penable;
    assign access = psel & penable;

    ////////////////////////////////////////////////////////////////////////////
    // Register writes take effect in the access phase; spin-up configuration bits 7:6 stay zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spin_cfg_reg <= fsc_pkg::SPIN_CFG_RST;
            tach_cfg_reg <= fsc_pkg::TACH_CFG_RST;
        end else if (access && pwrite) begin
            if (paddr == fsc_pkg::ADDR_SPIN_CFG) begin
                spin_cfg_reg <= {2'b00, pwdata[5:0]};
            end
            if (paddr == fsc_pkg::ADDR_TACH_CFG) begin
                tach_cfg_reg <= pwdata[7:0];
            end
        end
    end

    // Level seen by software hides the drive during spin-up.
    assign level_view = (state_reg == fsc_pkg::FSC_SPIN) ? 6'h00 : commanded_level;

    // Read data and error are registered in the setup phase; zero wait states.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                pslverr <= 1'b0;
                prdata  <= 32'h0000_0000;
                case (paddr)
                    fsc_pkg::ADDR_SPIN_CFG: prdata <= {24'h00_0000, spin_cfg_reg};
                    fsc_pkg::ADDR_TACH_CFG: prdata <= {24'h00_0000, tach_cfg_reg};
                    fsc_pkg::ADDR_LEVEL:    prdata <= {26'h0, level_view};
                    default:                pslverr <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interval length in base units: 1, 2, 4 ... 64.
    assign interval_ticks = (time_sel == 3'h0) ? 7'h00 : 7'(7'h01 << (time_sel - 3'h1));

    // Start when the commanded level leaves zero; bypass on zero interval, or on zero duty with fast start clear.
    assign start  = (level_prev_reg == 6'h00) && (commanded_level != 6'h00);
    assign bypass = (time_sel == 3'h0) ||
                    ((duty_sel == 2'b00) && !fast);

    // Tach ends a fast start only when the shared pin is set up as tach input.
    assign tach_done = fast && tach_sel && tach_at_setpoint;

    // One base unit elapsed on the prescaler.
    assign unit_tick = (pre_cnt_reg == PW'(UNIT_CYCLES - 1));

    // Previous commanded level for edge detection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_prev_reg <= 6'h00;
        end else begin
            level_prev_reg <= commanded_level;
        end
    end

    // Next state of the spin-up sequencer.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fsc_pkg::FSC_IDLE: begin
                if (start && !bypass) begin
                    state_next = fsc_pkg::FSC_SPIN;
                end
            end
            fsc_pkg::FSC_SPIN: begin
                if (commanded_level == 6'h00 || tach_done) begin
                    state_next = fsc_pkg::FSC_IDLE;
                end else if (unit_tick && ticks_left_reg == 7'h01) begin
                    state_next = fsc_pkg::FSC_IDLE;
                end
            end
            default: state_next = fsc_pkg::FSC_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= fsc_pkg::FSC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Prescaler and remaining-unit counter, loaded at the start of spin-up.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_reg    <= '0;
            ticks_left_reg <= 7'h00;
        end else if (state_reg == fsc_pkg::FSC_IDLE) begin
            pre_cnt_reg    <= '0;
            ticks_left_reg <= interval_ticks;
        end else if (unit_tick) begin
            pre_cnt_reg    <= '0;
            ticks_left_reg <= ticks_left_reg - 7'h01;
        end else begin
            pre_cnt_reg    <= pre_cnt_reg + PW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Spin-up compare value from the duty field, forced full in fast mode.
    always_comb begin
        case (duty_sel)
            2'b01:   spin_cmp = fsc_pkg::DUTY_HALF;
            2'b10:   spin_cmp = fsc_pkg::DUTY_3Q;
            2'b11:   spin_cmp = fsc_pkg::DUTY_FULL;
            default: spin_cmp = fsc_pkg::DUTY_OFF;
        endcase
        if (fast) begin
            spin_cmp = fsc_pkg::DUTY_FULL;
        end
    end

    // Spin-up duty overrides the normal level, which returns afterwards.
    assign cmp = (state_reg == fsc_pkg::FSC_SPIN) ? spin_cmp : {1'b0, commanded_level};

    // Free-running 64-step PWM period counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_cnt_reg <= 6'h00;
        end else begin
            pwm_cnt_reg <= pwm_cnt_reg + 6'h01;
        end
    end

    // Open-drain drive: the pin is released (fan on) while the count is below compare.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out     <= 1'b0;
            pwm_oe      <= 1'b1;
            spin_active <= 1'b0;
        end else begin
            pwm_out     <= 1'b0;
            pwm_oe      <= !({1'b0, pwm_cnt_reg} < cmp);
            spin_active <= (state_next == fsc_pkg::FSC_SPIN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the sequencer and register behaviour.
    rsvd_read_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == fsc_pkg::ADDR_SPIN_CFG) |=> (prdata[7:6] == 2'b00))
        else $error("Reserved configuration bits read nonzero.");

    spin_duty_sel_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == fsc_pkg::FSC_SPIN && !fast && duty_sel == 2'b01) |-> (cmp == 7'h20))
        else $error("Half duty not applied during spin-up.");

    spin_duty_3q_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == fsc_pkg::FSC_SPIN && !fast && duty_sel == 2'b10)
        |=> (pwm_oe == ($past(pwm_cnt_reg) >= 6'h30)))
        else $error("Three quarter duty not applied during spin-up.");

    fast_full_on_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == fsc_pkg::FSC_SPIN && fast) [*2] |=> !pwm_oe)
        else $error("Fast spin-up did not hold full duty.");

    tach_stop_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == fsc_pkg::FSC_SPIN && fast && tach_sel && tach_at_setpoint)
        |=> (state_reg == fsc_pkg::FSC_IDLE) ##1 !spin_active)
        else $error("Tach setpoint did not end spin-up.");

    time_zero_skip_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == fsc_pkg::FSC_IDLE && start && time_sel == 3'h0)
        |=> (state_reg == fsc_pkg::FSC_IDLE))
        else $error("Zero interval did not bypass spin-up.");

    duty_zero_skip_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == fsc_pkg::FSC_IDLE && start && time_sel != 3'h0 && duty_sel == 2'b00)
        |=> (state_reg == (fast ? fsc_pkg::FSC_SPIN : fsc_pkg::FSC_IDLE)))
        else $error("Zero duty bypass handled wrongly.");

    level_hidden_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == fsc_pkg::ADDR_LEVEL && state_reg == fsc_pkg::FSC_SPIN)
        |=> (prdata == 32'h0000_0000))
        else $error("Level register not zero during spin-up.");

    spin_start_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == fsc_pkg::FSC_IDLE && start && !bypass)
        |=> (state_reg == fsc_pkg::FSC_SPIN) ##0 (ticks_left_reg == $past(interval_ticks)))
        else $error("Spin-up did not start with the programmed interval.");

    level_drop_end_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == fsc_pkg::FSC_SPIN && commanded_level == 6'h00)
        |=> (state_reg == fsc_pkg::FSC_IDLE) ##0 !spin_active)
        else $error("Spin-up did not end when the level fell to zero.");

    interval_end_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == fsc_pkg::FSC_SPIN && unit_tick && ticks_left_reg == 7'h01)
        |=> (state_reg == fsc_pkg::FSC_IDLE))
        else $error("Spin-up outlasted its interval.");

    prescale_bound_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pre_cnt_reg <= PW'(UNIT_CYCLES - 1)))
        else $error("Prescaler ran past one base unit.");

    spin_normal_c: cover property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == fsc_pkg::FSC_SPIN && !fast) ##1 (state_reg == fsc_pkg::FSC_IDLE));

    spin_tach_c: cover property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == fsc_pkg::FSC_SPIN && tach_done));

    spin_bypass_c: cover property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == fsc_pkg::FSC_IDLE && start && bypass));

    spin_abort_c: cover property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == fsc_pkg::FSC_SPIN && commanded_level == 6'h00));

endmodule : fsc_top

//--- testbench/fsc_fan_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Four-pin fan: it speeds up while the open-drain line is released and
// reports the speed setpoint once enough powered cycles have accumulated.
module fsc_fan_model (
    input  wire logic        pclk,             // Device clock.
    input  wire logic        presetn,          // Reset, active low.
    input  wire logic        pwm_out,          // Open-drain value from the block.
    input  wire logic        pwm_oe,           // Pull-low enable from the block.
    input  wire logic        clr,              // Fan stopped: forget the speed.
    input  wire logic [15:0] need,             // Powered cycles to reach setpoint.
    output logic             tach_at_setpoint  // Speed has reached the setpoint.
);
    logic        pwm_line;
    logic [15:0] on_cnt;

    // The line has a pull-up, so a released pin reads high and powers the fan.
    assign pwm_line = pwm_oe ? pwm_out : 1'b1;

    // Powered cycles count up; a small need gives a prompt fan, a large one a slow fan.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_cnt <= 16'h0000;
        end else if (clr) begin
            on_cnt <= 16'h0000;
        end else if (pwm_line && on_cnt != 16'hffff) begin
            on_cnt <= on_cnt + 16'h0001;
        end
    end

    // The speed report is a plain level that follows the count.
    assign tach_at_setpoint = (on_cnt >= need);
endmodule : fsc_fan_model

//--- testbench/fsc_top_bench.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: drivers note expectations, watchers compare results.
module fsc_top_bench;
    localparam int UNIT = 64;
    logic        pclk, presetn, psel, penable, pwrite, fan_clr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, tach, pwm_out, pwm_oe, spin_active;
    logic [5:0]  commanded_level, lvl;
    logic [15:0] need;
    logic [32:0] rq[$];
    int          lq[$], oq[$];
    int          n_mismatch, n_tests, seed, cyc, len, on;

    fsc_top #(.UNIT_CYCLES(UNIT)) fsc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .commanded_level(commanded_level),
        .tach_at_setpoint(tach), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .spin_active(spin_active));
    fsc_fan_model fsc_fan_model_i (.pclk(pclk), .presetn(presetn), .pwm_out(pwm_out),
        .pwm_oe(pwm_oe), .clr(fan_clr), .need(need), .tach_at_setpoint(tach));

    // Clock of 25 ns period.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then stops.
    task finish_test;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    // Exact four-state comparison.
    task chk(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Cycle count comparison allowing a few edges of slack for start and end alignment.
    task near(input int got, input int exp);
        n_tests++;
        if (got > exp + 3 || got < exp - 3) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : near

    // One APB transfer; the request holds until pready is sampled high.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Read with its expected {pslverr, prdata} noted first.
    task rd(input logic [11:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    // Programs the start, stops the fan, then commands a random nonzero level.
    task spin(input logic [7:0] cfg, input int elen, input int eon);
        int k;
        apb(1'b1, fsc_pkg::ADDR_SPIN_CFG, {24'h000000, cfg});
        commanded_level <= 6'h00;
        fan_clr <= 1'b1;
        repeat (4) @(posedge pclk);
        lvl = 6'($random(seed)) | 6'h01;
        fan_clr <= 1'b0;
        commanded_level <= lvl;
        if (elen > 0) begin
            lq.push_back(elen);
            oq.push_back(eon);
            k = 0;
            do begin
                @(posedge pclk);
                k++;
            end while (spin_active !== 1'b1 && k < 20);
            rd(fsc_pkg::ADDR_LEVEL, 33'h0_0000_0000);
            k = 0;
            while (spin_active !== 1'b0 && k < elen + 20) begin
                @(posedge pclk);
                k++;
            end
        end else begin
            repeat (100) @(posedge pclk);
        end
        rd(fsc_pkg::ADDR_LEVEL, {27'h0, lvl});
    endtask : spin

    ////////////////////////////////////////////////////////////////////////////
    // Watches read answers and measures each spin-up phase as it ends.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk({pslverr, prdata}, (rq.size() > 0) ? rq.pop_front() : 33'bx);
        end
        if (spin_active === 1'b1) begin
            len++;
            on += (pwm_oe === 1'b0) ? 1 : 0;
        end else if (len > 0) begin
            near(len, (lq.size() > 0) ? lq.pop_front() : -99);
            near(on, (oq.size() > 0) ? oq.pop_front() : -99);
            chk({32'h0000_0000, pwm_out}, 33'h0_0000_0000);
            len = 0;
            on = 0;
        end
    end

    // Cuts a hang short.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            finish_test();
        end
    end

    // Main sequence.
    initial begin
        int d;
        int cmp;
        seed = 44;
        {psel, penable, pwrite, fan_clr, presetn} = 5'b00010;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        commanded_level = 6'h00;
        need = 16'd100;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(fsc_pkg::ADDR_SPIN_CFG, 33'h0_0000_003f);
        rd(fsc_pkg::ADDR_TACH_CFG, 33'h0_0000_0000);
        apb(1'b1, fsc_pkg::ADDR_SPIN_CFG, 32'($random(seed)) | 32'h0000_00c0);
        rd(fsc_pkg::ADDR_SPIN_CFG, {25'h0, 2'b00, 6'(pwdata)});
        apb(1'b1, 12'h800 | (12'($random(seed)) & 12'h7fc), 32'h0000_0000);
        rd(12'h800 | (12'($random(seed)) & 12'h7fc), 33'h1_0000_0000);
        apb(1'b1, fsc_pkg::ADDR_LEVEL, 32'h0000_0015);
        for (int c = 1; c <= 7; c++) begin
            d = (c - 1) % 3 + 1;
            cmp = ((d == 1) ? 32 : (d == 2) ? 48 : 64) << (c - 1);
            spin({3'b000, 2'(d), 3'(c)}, UNIT << (c - 1), cmp);
        end
        spin(8'h21, UNIT, UNIT);
        spin(8'h28, 0, 0);
        spin(8'h03, 0, 0);
        spin(8'h23, UNIT * 4, UNIT * 4);
        apb(1'b1, fsc_pkg::ADDR_TACH_CFG, 32'h0000_0004);
        rd(fsc_pkg::ADDR_TACH_CFG, 33'h0_0000_0004);
        spin(8'h2b, 101, 101);
        // Mid-run reset with the fan stopped: registers return to their reset values.
        commanded_level <= 6'h00;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(fsc_pkg::ADDR_SPIN_CFG, 33'h0_0000_003f);
        rd(fsc_pkg::ADDR_TACH_CFG, 33'h0_0000_0000);
        // A level that falls back to zero cuts a fast full-duty spin-up short.
        lq.push_back(40);
        oq.push_back(40);
        lvl = 6'($random(seed)) | 6'h01;
        commanded_level <= lvl;
        repeat (40) @(posedge pclk);
        commanded_level <= 6'h00;
        repeat (4) @(posedge pclk);
        rd(fsc_pkg::ADDR_LEVEL, 33'h0_0000_0000);
        // Every noted spin-up must have been measured.
        chk(33'(lq.size()), 33'h0_0000_0000);
        finish_test();
    end
endmodule : fsc_top_bench
